// file: bench/flash_dev_model.sv
// Behavioural flash device: identifier codes and per-sector protection
module flash_dev_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5a,  // Arbitrary value, not a real maker code
    parameter logic [7:0] DEVICE_CODE = 8'h3c  // Arbitrary value, not a real part code
) (
    // Bus strobes and address
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [19:0] addr,
    // Data from the host while it writes
    input wire logic [7:0] data_out,
    // High voltage switches
    input wire logic hv_line_nine,
    input wire logic hv_reset,
    // Data towards the host
    output logic [7:0] low_data_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prot_ff [256];  // Stored protection bit per sector
    logic [7:0] id_val;  // Selected identifier
    logic [7:0] last_val;  // Last byte driven, inverted once released
    logic write_ok;  // Program or erase would be accepted here
    // Identifiers only appear with high voltage on line nine and both strobes low
    wire reading = !ce_n && !oe_n && hv_line_nine;
    // Shipped with every sector clear
    initial begin
        foreach (prot_ff[i]) prot_ff[i] = 1'b0;
    end
    // Line six low, lines one and zero pick the identifier
    always_comb begin
        case ({addr[6], addr[1:0]})
            3'h0: id_val = MAKER_CODE;
            3'h1: id_val = DEVICE_CODE;
            3'h2: id_val = {7'h00, prot_ff[addr[19:12]]};
            default: id_val = 8'hff;
        endcase
    end
    // Masked only while reset high voltage stands; stored bits untouched
    assign write_ok = !prot_ff[addr[19:12]] || hv_reset;
    // Remember the last driven byte so a released bus does not look valid
    always @* begin
        if (reading) last_val = id_val;
    end
    assign low_data_byte = reading ? id_val : ~last_val;
    // Protect or unprotect on the closing write edge under reset high voltage
    always @(posedge we_n) begin
        if (!ce_n && hv_reset) prot_ff[addr[19:12]] <= (data_out == 8'h01);
    end
endmodule

// file: bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER = 8'h5a;  // Arbitrary value
    localparam logic [7:0] DEVID = 8'h3c;  // Arbitrary value
    logic mclk, rstn, job_valid, job_ready, done_ff, shadow_prot_ff;
    logic [1:0] job_op, job_sel;
    logic [7:0] job_sector, id_data_ff, din, dout;
    logic [5:0] job_index;
    logic ce_n, oe_n, we_n, doe, hv9, hvr, hvoe;
    logic [19:0] addr;
    int fails, compares;
    logic [7:0] rd;
    flash_ident_host u_dut (.mclk(mclk), .rstn(rstn), .job_valid(job_valid), .job_ready(job_ready),
        .job_op(job_op), .job_sel(job_sel), .job_sector(job_sector), .job_index(job_index),
        .done_ff(done_ff), .id_data_ff(id_data_ff), .shadow_prot_ff(shadow_prot_ff),
        .ce_n_ff(ce_n), .oe_n_ff(oe_n), .we_n_ff(we_n), .addr_ff(addr), .low_data_byte_in(din),
        .low_data_byte_out_ff(dout), .low_data_byte_oe_ff(doe), .hv_line_nine_ff(hv9),
        .hv_reset_ff(hvr), .hv_oe_ff(hvoe));
    flash_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID)) u_dev (.ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .addr(addr), .data_out(dout), .hv_line_nine(hv9), .hv_reset(hvr),
        .low_data_byte(din));
    // Free-running clock, 100 ns period
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Compare one byte and report at once
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One job; job_valid is held for hold + 1 cycles to stretch a temporary unprotect
    task automatic do_job(input logic [1:0] op, input logic [1:0] sel, input logic [7:0] sect,
                          input int hold, output logic [7:0] res);
        int n;
        @(posedge mclk);
        job_op <= op;
        job_sel <= sel;
        job_sector <= sect;
        job_index <= sect[5:0];
        job_valid <= 1'b1;
        repeat (hold + 1) @(posedge mclk);
        job_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (done_ff !== 1'b1 && n < 200);
        if (n >= 200) begin
            fails++;
            $display("MISMATCH done_ff expected 1 seen %b", done_ff);
        end
        res = id_data_ff;
        chk("ready", 8'h01, {7'h00, job_ready});
    endtask
    task automatic t_ident;
        do_job(flash_ident_pkg::OP_READ_ID, flash_ident_pkg::SEL_MAKER, 8'h00, 0, rd);
        chk("maker", MAKER, rd);
        do_job(flash_ident_pkg::OP_READ_ID, flash_ident_pkg::SEL_DEVICE, 8'h00, 0, rd);
        chk("device", DEVID, rd);
        chk("alt hv off", 8'h00, {7'h00, hvoe});
        $display("test ident done");
    endtask
    task automatic t_protect;
        do_job(flash_ident_pkg::OP_READ_ID, flash_ident_pkg::SEL_PROTECT, 8'h05, 0, rd);
        chk("status fresh", 8'h00, rd);
        do_job(flash_ident_pkg::OP_PROTECT, 2'h0, 8'h05, 0, rd);
        do_job(flash_ident_pkg::OP_READ_ID, flash_ident_pkg::SEL_PROTECT, 8'h05, 0, rd);
        chk("status set", 8'h01, rd);
        chk("shadow", 8'h01, {7'h00, shadow_prot_ff});
        do_job(flash_ident_pkg::OP_READ_ID, flash_ident_pkg::SEL_PROTECT, 8'h06, 0, rd);
        chk("status other", 8'h00, rd);
        $display("test protect done");
    endtask
    task automatic t_temp;
        fork
            do_job(flash_ident_pkg::OP_TEMP, 2'h0, 8'h05, 6, rd);
            begin
                repeat (5) @(posedge mclk);
                @(negedge mclk);
                chk("hv reset held", 8'h01, {7'h00, hvr});
                chk("write open", 8'h01, {7'h00, u_dev.write_ok});
            end
        join
        chk("write closed", 8'h00, {7'h00, u_dev.write_ok});
        do_job(flash_ident_pkg::OP_READ_ID, flash_ident_pkg::SEL_PROTECT, 8'h05, 0, rd);
        chk("status restored", 8'h01, rd);
        $display("test temp done");
    endtask
    task automatic t_unprotect;
        // Unprotect before every sector is protected must be held back
        do_job(flash_ident_pkg::OP_UNPROTECT, 2'h0, 8'h05, 0, rd);
        do_job(flash_ident_pkg::OP_READ_ID, flash_ident_pkg::SEL_PROTECT, 8'h05, 0, rd);
        chk("unprotect held back", 8'h01, rd);
        // Protect every sector still unprotected
        for (int s = 0; s < flash_ident_pkg::NUM_SECTORS; s++) begin
            do_job(flash_ident_pkg::OP_READ_ID, flash_ident_pkg::SEL_PROTECT, 8'(s), 0, rd);
            if (rd == 8'h00) do_job(flash_ident_pkg::OP_PROTECT, 2'h0, 8'(s), 0, rd);
        end
        do_job(flash_ident_pkg::OP_UNPROTECT, 2'h0, 8'h05, 0, rd);
        do_job(flash_ident_pkg::OP_READ_ID, flash_ident_pkg::SEL_PROTECT, 8'h05, 0, rd);
        chk("status cleared", 8'h00, rd);
        do_job(flash_ident_pkg::OP_READ_ID, flash_ident_pkg::SEL_PROTECT, 8'h06, 0, rd);
        chk("other kept", 8'h01, rd);
        $display("test unprotect done");
    endtask
    // Single exit point for the run
    task automatic test_done;
        $display("checks %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence: reset for 8 cycles, then the scenarios
    initial begin
        rstn = 1'b0;
        job_valid = 1'b0;
        job_op = 2'h0;
        job_sel = 2'h0;
        job_sector = 8'h00;
        job_index = 6'h00;
        fails = 0;
        compares = 0;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        t_ident();
        t_protect();
        t_temp();
        t_unprotect();
        test_done();
    end
    // Watchdog sized well beyond about eighty jobs of around ten cycles each
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        test_done();
    end
endmodule

// file: common/flash_ident_pkg.sv
package flash_ident_pkg;
    // Address field positions on the flash address bus (word mode)
    localparam int ADDR_W = 20;
    localparam int A0_BIT = 0;
    localparam int A1_BIT = 1;
    localparam int A6_BIT = 6;
    localparam int SECT_LSB = 12;
    localparam int SECT_W = 8;
    localparam int NUM_SECTORS = 35;
    localparam int SECT_IDX_W = 6;
    // Clock rate and pin timing
    localparam int CLK_MHZ = 10;
    localparam int T_ACC_NS = 100;
    localparam int T_ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int T_WP_NS = 100;
    localparam int T_WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int CNT_W = 8;
    // Identifier select codes on address lines one and zero
    localparam logic [1:0] SEL_MAKER = 2'h0;
    localparam logic [1:0] SEL_DEVICE = 2'h1;
    localparam logic [1:0] SEL_PROTECT = 2'h2;
    // Protection status values on the low data byte
    localparam logic [7:0] PROT_CLEAR = 8'h00;
    localparam logic [7:0] PROT_SET = 8'h01;
    // Job opcodes
    localparam logic [1:0] OP_READ_ID = 2'h0;
    localparam logic [1:0] OP_PROTECT = 2'h1;
    localparam logic [1:0] OP_UNPROTECT = 2'h2;
    localparam logic [1:0] OP_TEMP = 2'h3;
    // Controller states
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_SETUP = 6'h02,
        ST_READ  = 6'h04,
        ST_WRITE = 6'h08,
        ST_SCAN  = 6'h10,
        ST_DONE  = 6'h20
    } state_t;
endpackage

// file: logic/flash_ident_host.sv
// What this block does
// - Hold high voltage on line nine during identifier read jobs only
// - Lines one, zero pick identifier with six low
// - Sector address on top address lines
// - Protect uses reset high voltage, bus cycles
// - Protect all sectors before first unprotect
// - Alternate method needs line nine, OE high; not used here, hv_oe_ff kept low
module flash_ident_host #(
    parameter int NSECT = flash_ident_pkg::NUM_SECTORS,
    parameter int ACC_CYC = flash_ident_pkg::T_ACC_CYC,
    parameter int WP_CYC = flash_ident_pkg::T_WP_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Job request
    input wire logic job_valid,
    output logic job_ready,
    input wire logic [1:0] job_op,
    input wire logic [1:0] job_sel,
    input wire logic [flash_ident_pkg::SECT_W-1:0] job_sector,
    input wire logic [flash_ident_pkg::SECT_IDX_W-1:0] job_index,
    // Job answer
    output logic done_ff,
    output logic [7:0] id_data_ff,
    output logic shadow_prot_ff,
    // Flash bus pins
    output logic ce_n_ff,
    output logic oe_n_ff,
    output logic we_n_ff,
    output logic [flash_ident_pkg::ADDR_W-1:0] addr_ff,
    input wire logic [7:0] low_data_byte_in,
    output logic [7:0] low_data_byte_out_ff,
    output logic low_data_byte_oe_ff,
    // High voltage switch controls
    output logic hv_line_nine_ff,
    output logic hv_reset_ff,
    output logic hv_oe_ff
);
    // Controller state and counters
    flash_ident_pkg::state_t state_ff;
    flash_ident_pkg::state_t nxt_state;
    logic [flash_ident_pkg::CNT_W-1:0] cnt_ff;
    logic [1:0] op_ff;
    logic [flash_ident_pkg::SECT_IDX_W-1:0] idx_ff;
    logic [1:0] sel_ff; // Identifier select latched with the job
    // Sectors last known protected, one bit each
    logic [NSECT-1:0] prot_known_ff;
    // Two-flop synchroniser on the data pins
    logic [7:0] din_meta_ff;
    logic [7:0] din_sync_ff;

    // Address word: identifier select with line six low, sector on top lines
    function automatic logic [flash_ident_pkg::ADDR_W-1:0] id_addr(
        input logic [1:0] sel, input logic [flash_ident_pkg::SECT_W-1:0] sect);
        logic [flash_ident_pkg::ADDR_W-1:0] a;
        a = '0;
        a[flash_ident_pkg::A0_BIT] = sel[0];
        a[flash_ident_pkg::A1_BIT] = sel[1];
        a[flash_ident_pkg::A6_BIT] = 1'b0;
        a[flash_ident_pkg::SECT_LSB +: flash_ident_pkg::SECT_W] = sect;
        return a;
    endfunction

    // Decode of phase and counter terms
    wire logic cnt_zero = (cnt_ff == '0);
    wire logic is_write_op = (op_ff == flash_ident_pkg::OP_PROTECT) || (op_ff == flash_ident_pkg::OP_UNPROTECT);
    wire logic is_temp = (op_ff == flash_ident_pkg::OP_TEMP);
    wire logic is_read = (op_ff == flash_ident_pkg::OP_READ_ID);
    wire logic take_job = job_valid && (state_ff == flash_ident_pkg::ST_IDLE);
    wire logic [7:0] status_byte = din_sync_ff;
    wire logic prot_bit = (status_byte == flash_ident_pkg::PROT_SET);
    // Latched select, so a host changing job_sel mid-job cannot corrupt the shadow
    wire logic status_read = is_read && (sel_ff == flash_ident_pkg::SEL_PROTECT);
    wire logic shadow_wr = (state_ff == flash_ident_pkg::ST_READ) && cnt_zero && status_read;
    // Unprotect is held back until every sector is known protected
    wire logic unprot_blocked = (op_ff == flash_ident_pkg::OP_UNPROTECT) && !(&prot_known_ff);
    // Slots past the last sector are not tracked
    wire logic sect_in_range = (32'(idx_ff) < NSECT);

    assign job_ready = (state_ff == flash_ident_pkg::ST_IDLE);

    // Pin synchroniser: first stage feeds only the second
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            din_meta_ff <= 8'h00;
            din_sync_ff <= 8'h00;
        end else begin
            din_meta_ff <= low_data_byte_in;
            din_sync_ff <= din_meta_ff;
        end
    end

    // Next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            flash_ident_pkg::ST_IDLE: if (job_valid) nxt_state = flash_ident_pkg::ST_SETUP;
            flash_ident_pkg::ST_SETUP: begin
                if (cnt_zero) begin
                    if (is_temp) nxt_state = flash_ident_pkg::ST_SCAN;
                    else if (unprot_blocked) nxt_state = flash_ident_pkg::ST_DONE;
                    else if (is_write_op) nxt_state = flash_ident_pkg::ST_WRITE;
                    else nxt_state = flash_ident_pkg::ST_READ;
                end
            end
            flash_ident_pkg::ST_WRITE: if (cnt_zero) nxt_state = flash_ident_pkg::ST_READ;
            flash_ident_pkg::ST_READ: if (cnt_zero) nxt_state = flash_ident_pkg::ST_DONE;
            // Temporary unprotect window held until job_valid drops
            flash_ident_pkg::ST_SCAN: if (!job_valid) nxt_state = flash_ident_pkg::ST_DONE;
            flash_ident_pkg::ST_DONE: nxt_state = flash_ident_pkg::ST_IDLE;
            default: nxt_state = flash_ident_pkg::ST_IDLE;
        endcase
    end

    // State, counter and latched job
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= flash_ident_pkg::ST_IDLE;
            cnt_ff <= '0;
            op_ff <= flash_ident_pkg::OP_READ_ID;
            idx_ff <= '0;
            sel_ff <= flash_ident_pkg::SEL_MAKER;
        end else begin
            state_ff <= nxt_state;
            if (take_job) begin
                op_ff <= job_op;
                idx_ff <= job_index;
                sel_ff <= job_sel;
                cnt_ff <= flash_ident_pkg::CNT_W'(ACC_CYC);
            end else if (nxt_state != state_ff) begin
                cnt_ff <= (nxt_state == flash_ident_pkg::ST_WRITE) ? flash_ident_pkg::CNT_W'(WP_CYC)
                                                                   : flash_ident_pkg::CNT_W'(ACC_CYC);
            end else if (!cnt_zero) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end

    // Protection bookkeeping: protect writes set it, unprotect clears, status reads load the bit read
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prot_known_ff <= '0;
        end else if (sect_in_range) begin
            if ((state_ff == flash_ident_pkg::ST_WRITE) && cnt_zero) begin
                prot_known_ff[idx_ff] <= (op_ff == flash_ident_pkg::OP_PROTECT);
            end else if (shadow_wr) begin
                prot_known_ff[idx_ff] <= prot_bit;
            end
        end
    end

    // Flash pins; high voltage only on the pins each method names
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ce_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            addr_ff <= '0;
            low_data_byte_out_ff <= 8'h00;
            low_data_byte_oe_ff <= 1'b0;
            hv_line_nine_ff <= 1'b0;
            hv_reset_ff <= 1'b0;
            hv_oe_ff <= 1'b0;
        end else begin
            if (take_job) begin
                addr_ff <= id_addr(job_sel, job_sector);
                hv_line_nine_ff <= (job_op == flash_ident_pkg::OP_READ_ID);
                // Primary method and temporary unprotect raise only the reset pin
                hv_reset_ff <= (job_op != flash_ident_pkg::OP_READ_ID);
                hv_oe_ff <= 1'b0;
            end
            ce_n_ff <= (nxt_state == flash_ident_pkg::ST_IDLE) || (nxt_state == flash_ident_pkg::ST_DONE)
                       || (nxt_state == flash_ident_pkg::ST_SCAN);
            oe_n_ff <= (nxt_state != flash_ident_pkg::ST_READ);
            we_n_ff <= (nxt_state != flash_ident_pkg::ST_WRITE);
            low_data_byte_oe_ff <= (nxt_state == flash_ident_pkg::ST_WRITE);
            low_data_byte_out_ff <= (op_ff == flash_ident_pkg::OP_UNPROTECT) ? flash_ident_pkg::PROT_CLEAR
                                                                               : flash_ident_pkg::PROT_SET;
            if (nxt_state == flash_ident_pkg::ST_IDLE) begin
                // Removing high voltage ends temporary unprotect
                hv_line_nine_ff <= 1'b0;
                hv_reset_ff <= 1'b0;
            end
        end
    end

    // Answer byte captured at end of read strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            id_data_ff <= 8'h00;
            done_ff <= 1'b0;
        end else begin
            done_ff <= (state_ff == flash_ident_pkg::ST_DONE);
            if ((state_ff == flash_ident_pkg::ST_READ) && cnt_zero) begin
                id_data_ff <= status_byte;
            end
        end
    end

    // Shadow of per-sector protection, last seen
    prot_shadow_mem #(.DEPTH(NSECT), .AW(flash_ident_pkg::SECT_IDX_W)) u_shadow (
        .mclk(mclk),
        .wr_en(shadow_wr),
        .wr_addr(idx_ff),
        .wr_data(prot_bit),
        .rd_addr(job_index),
        .rd_data_ff(shadow_prot_ff)
    );

    // Checks
    a_we_oe_excl: assert property (@(posedge mclk) disable iff (!rstn)
        !(!we_n_ff && !oe_n_ff)) else $error("write and read strobes overlap");
    a_hv_read: assert property (@(posedge mclk) disable iff (!rstn)
        (!oe_n_ff && is_read) |-> hv_line_nine_ff && !hv_reset_ff) else $error("identification voltage wrong");
    a_hv_oe_off: assert property (@(posedge mclk) disable iff (!rstn)
        !hv_oe_ff) else $error("alternate method used");
    a_line_six_low: assert property (@(posedge mclk) disable iff (!rstn)
        !ce_n_ff |-> !addr_ff[flash_ident_pkg::A6_BIT]) else $error("line six high in identification");
    a_hv_released: assert property (@(posedge mclk) disable iff (!rstn)
        (state_ff == flash_ident_pkg::ST_IDLE) ##1 (state_ff == flash_ident_pkg::ST_IDLE)
        |-> !hv_reset_ff) else $error("reset high voltage left on");
    a_temp_hold: assert property (@(posedge mclk) disable iff (!rstn)
        (state_ff == flash_ident_pkg::ST_SCAN) |-> hv_reset_ff && ce_n_ff) else $error("temporary window lost");
    a_done_pulse: assert property (@(posedge mclk) disable iff (!rstn)
        done_ff |=> !done_ff) else $error("done longer than a cycle");
    a_read_len: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(oe_n_ff) |-> !oe_n_ff [*2]) else $error("read strobe too short");
    a_data_drive: assert property (@(posedge mclk) disable iff (!rstn)
        low_data_byte_oe_ff == !we_n_ff) else $error("data drive outside write strobe");
    c_read_id: cover property (@(posedge mclk) disable iff (!rstn) take_job && is_read ##[1:20] done_ff);
    c_protect: cover property (@(posedge mclk) disable iff (!rstn) $fell(we_n_ff));
    c_temp: cover property (@(posedge mclk) disable iff (!rstn) state_ff == flash_ident_pkg::ST_SCAN);
endmodule

// file: logic/prot_shadow_mem.sv
// Small per-sector memory holding the last read protection status
module prot_shadow_mem #(
    parameter int DEPTH = 35,
    parameter int AW = 6
) (
    // Clock
    input wire logic mclk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic wr_data,
    // Registered read port
    input wire logic [AW-1:0] rd_addr,
    output logic rd_data_ff
);
    // Storage; contents undefined until first status read
    logic mem [DEPTH];

    // Write and registered read
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_ff <= mem[rd_addr];
    end
endmodule
